/* tb/pbs_host_model.sv */
// Behavioural host processor answering the sequencer handshake.
`timescale 1ns/100ps
`default_nettype none
module pbs_host_model #(
    parameter int RAISE_CYCLES = 400,
    parameter int CLEAN_CYCLES = 200
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic sys_rst,
    // Sequencer view; bit 0 of hostMode boots, bit 1 answers interrupts.
    input wire logic powerOn,
    input wire logic interrupt_n,
    input wire logic [1:0] hostMode,
    // Request toward the sequencer.
    output logic shutdownRequest_n
);
    int bootCnt, cleanCnt;
    // An unpowered host cannot hold the request high.
    always @(posedge core_clk) begin
        if (sys_rst || !powerOn) begin
            bootCnt <= 0;
            cleanCnt <= 0;
            shutdownRequest_n <= 1'b0;
        end else begin
            if (bootCnt < RAISE_CYCLES)
                bootCnt <= bootCnt + 1;
            else if (hostMode[0] && cleanCnt == 0)
                shutdownRequest_n <= 1'b1;
            if ((!interrupt_n || cleanCnt != 0) && hostMode[1]
                && cleanCnt < CLEAN_CYCLES)
                cleanCnt <= cleanCnt + 1;
            if (cleanCnt == CLEAN_CYCLES)
                shutdownRequest_n <= 1'b0;
        end
    end
endmodule // pbs_host_model
`default_nettype wire

/* tb/pbs_props.sv */
// Port checks for the push button power sequencer.
`timescale 1ns/100ps
`default_nettype none
module pbs_props #(
    parameter int TICK_CYCLES = 4,
    parameter bit ENABLE_ACTIVE_HIGH = 1'b1,
    parameter int EXTRA_PD_MS_DEFAULT = 0
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic sys_rst,
    // Inputs.
    input wire logic push_button_n,
    input wire logic shutdownRequest_n,
    input wire logic undervoltage_lockout_in,
    input wire logic power_fail_in,
    input wire logic supervised_voltage_in,
    input wire logic [pbs_pkg::MS_WIDTH-1:0] power_down_timer_cap,
    // Outputs.
    input wire logic supplyEnable,
    input wire logic interrupt_n,
    input wire logic power_fail_out_n,
    input wire logic supervisorReset_n
);
    localparam int TK = TICK_CYCLES;
    localparam int BLK = 512 * TK + 8;
    localparam int HOLD = 510 * TK;
    logic enAct;
    int pbLow, uvLow, okCnt, onCnt, intLow, pdMin;
    assign enAct = supplyEnable == ENABLE_ACTIVE_HIGH;
    assign pdMin = (63 + EXTRA_PD_MS_DEFAULT + int'(power_down_timer_cap)) * TK;
    // Raw-input run lengths lead the synchronised view inside the block.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pbLow <= 0;
            uvLow <= 0;
            okCnt <= 0;
            onCnt <= 0;
            intLow <= 0;
        end else begin
            pbLow <= push_button_n ? 0 : pbLow + 1;
            uvLow <= undervoltage_lockout_in ? 0 : uvLow + 1;
            okCnt <= supervised_voltage_in ? okCnt + 1 : 0;
            onCnt <= enAct ? onCnt + 1 : 0;
            intLow <= interrupt_n ? 0 : intLow + 1;
        end
    end
    default clocking @(posedge core_clk); endclocking
    sequence killHeld;
        (!shutdownRequest_n) [*6];
    endsequence
    chk_enable_qual: assert property (disable iff (sys_rst) $rose(enAct) |->
        pbLow >= 31 * TK && $past(undervoltage_lockout_in, 5)) else $error("enable rose early");
    chk_blank_hold: assert property (disable iff (sys_rst)
        enAct && onCnt < HOLD |=> enAct) else $error("enable lost in blanking");
    chk_kill_off: assert property (disable iff (sys_rst)
        (onCnt > BLK && !shutdownRequest_n) ##0 killHeld |-> !enAct)
        else $error("kill did not release enable");
    chk_int_cause: assert property (disable iff (sys_rst) $fell(interrupt_n) |->
        enAct && (pbLow >= 31 * TK || uvLow >= 31 * TK)) else $error("interrupt unprompted");
    chk_int_width: assert property (disable iff (sys_rst)
        $rose(interrupt_n) |-> intLow >= 31 * TK) else $error("interrupt too short");
    chk_forced_off: assert property (disable iff (sys_rst)
        $fell(enAct) && shutdownRequest_n |-> (pbLow >= pdMin || uvLow >= pdMin)
        ##[0:2] interrupt_n) else $error("forced release wrong");
    chk_rst_stretch: assert property (disable iff (sys_rst) $rose(supervisorReset_n)
        |-> okCnt >= 199 * TK && okCnt <= 201 * TK + 4) else $error("stretch wrong");
    chk_rst_low: assert property (disable iff (sys_rst)
        (!supervised_voltage_in) [*5] |-> !supervisorReset_n) else $error("reset not low");
    chk_pfo_follow: assert property (disable iff (sys_rst) $stable(power_fail_in) [*5]
        |-> power_fail_out_n == power_fail_in) else $error("power fail not followed");
    chk_reset_state: assert property (sys_rst [*2] |-> !enAct && interrupt_n
        && !supervisorReset_n && power_fail_out_n) else $error("reset state wrong");
endmodule // pbs_props
bind push_button_power_sequencer pbs_props #(.TICK_CYCLES(TICK_CYCLES),
    .ENABLE_ACTIVE_HIGH(ENABLE_ACTIVE_HIGH),
    .EXTRA_PD_MS_DEFAULT(EXTRA_PD_MS_DEFAULT)) i_pbs_props (
    .core_clk(core_clk), .sys_rst(sys_rst), .push_button_n(push_button_n),
    .shutdownRequest_n(shutdownRequest_n), .power_fail_in(power_fail_in),
    .undervoltage_lockout_in(undervoltage_lockout_in),
    .supervised_voltage_in(supervised_voltage_in), .interrupt_n(interrupt_n),
    .power_down_timer_cap(power_down_timer_cap), .supplyEnable(supplyEnable),
    .power_fail_out_n(power_fail_out_n), .supervisorReset_n(supervisorReset_n));
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the push button power sequencer.
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int TK = 4;
    logic core_clk = 1'b0, sys_rst = 1'b1, push_button_n = 1'b1;
    logic undervoltage_lockout_in = 1'b1, power_fail_in = 1'b1;
    logic supervised_voltage_in = 1'b1, shutdownRequest_n;
    logic [pbs_pkg::MS_WIDTH-1:0] power_down_timer_cap = 16'h0000;
    logic [1:0] hostMode = 2'h3;
    logic supplyEnable, enLow, interrupt_n, power_fail_out_n, supervisorReset_n;
    int failCount = 0, checked = 0, cycles = 0;
    push_button_power_sequencer #(.TICK_CYCLES(TK))
        i_push_button_power_sequencer (.core_clk(core_clk), .sys_rst(sys_rst),
        .push_button_n(push_button_n), .shutdownRequest_n(shutdownRequest_n),
        .undervoltage_lockout_in(undervoltage_lockout_in),
        .power_fail_in(power_fail_in), .interrupt_n(interrupt_n),
        .supervised_voltage_in(supervised_voltage_in),
        .power_down_timer_cap(power_down_timer_cap), .supplyEnable(supplyEnable),
        .power_fail_out_n(power_fail_out_n), .supervisorReset_n(supervisorReset_n));
    push_button_power_sequencer #(.TICK_CYCLES(TK), .ENABLE_ACTIVE_HIGH(1'b0))
        i_push_button_power_sequencer_low (.core_clk(core_clk), .sys_rst(sys_rst),
        .push_button_n(push_button_n), .shutdownRequest_n(shutdownRequest_n),
        .undervoltage_lockout_in(undervoltage_lockout_in),
        .power_fail_in(power_fail_in), .interrupt_n(),
        .supervised_voltage_in(supervised_voltage_in),
        .power_down_timer_cap(power_down_timer_cap), .supplyEnable(enLow),
        .power_fail_out_n(), .supervisorReset_n());
    pbs_host_model #(.RAISE_CYCLES(100 * TK), .CLEAN_CYCLES(50 * TK))
        i_pbs_host_model (.core_clk(core_clk), .sys_rst(sys_rst),
        .powerOn(supplyEnable), .interrupt_n(interrupt_n), .hostMode(hostMode),
        .shutdownRequest_n(shutdownRequest_n));
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 25000) begin
            failCount = failCount + 1;
            completeRun();
        end
    end
    task automatic step(input int ms);
        repeat (ms * TK) @(posedge core_clk);
        #1;
    endtask
    task automatic chkBit(input logic got, input logic exp);
        checked = checked + 1;
        if (got !== exp) begin
            failCount = failCount + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkEn(input logic exp);
        chkBit(supplyEnable, exp);
        chkBit(enLow, !exp);
    endtask
    task automatic press(input int ms);
        push_button_n = 1'b0;
        step(ms);
        push_button_n = 1'b1;
    endtask
    task automatic powerOn;
        press(40);
        step(520);
        chkEn(1'b1);
    endtask
    task automatic completeRun;
        if (failCount == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic tSupervisor;
        chkEn(1'b0);
        chkBit(interrupt_n, 1'b1);
        step(190);
        chkBit(supervisorReset_n, 1'b0);
        step(15);
        chkBit(supervisorReset_n, 1'b1);
        supervised_voltage_in = 1'b0;
        power_fail_in = 1'b0;
        step(1);
        chkBit(supervisorReset_n, 1'b0);
        chkBit(power_fail_out_n, 1'b0);
        supervised_voltage_in = 1'b1;
        power_fail_in = 1'b1;
        step(1);
        chkBit(power_fail_out_n, 1'b1);
        step(195);
        chkBit(supervisorReset_n, 1'b0);
        step(10);
        chkBit(supervisorReset_n, 1'b1);
    endtask
    task automatic tGlitchOn;
        press(20);
        step(5);
        press(20);
        step(5);
        chkEn(1'b0);
        push_button_n = 1'b0;
        step(30);
        chkEn(1'b0);
        step(4);
        chkEn(1'b1);
        push_button_n = 1'b1;
        step(530);
    endtask
    task automatic tShortPress;
        press(40);
        chkBit(interrupt_n, 1'b0);
        step(20);
        chkBit(interrupt_n, 1'b0);
        chkEn(1'b1);
        step(40);
        chkEn(1'b0);
    endtask
    task automatic tForced;
        hostMode = 2'h1;
        power_down_timer_cap = 16'h0008;
        powerOn();
        push_button_n = 1'b0;
        step(70);
        chkBit(interrupt_n, 1'b0);
        chkEn(1'b1);
        step(4);
        chkEn(1'b0);
        chkBit(interrupt_n, 1'b1);
        push_button_n = 1'b1;
        power_down_timer_cap = 16'h0000;
        step(10);
    endtask
    task automatic tAbort;
        hostMode = 2'h0;
        press(40);
        step(100);
        press(100);
        step(300);
        chkEn(1'b1);
        step(80);
        chkEn(1'b0);
    endtask
    task automatic tUvlo;
        hostMode = 2'h1;
        powerOn();
        undervoltage_lockout_in = 1'b0;
        step(40);
        undervoltage_lockout_in = 1'b1;
        chkBit(interrupt_n, 1'b0);
        chkEn(1'b1);
        step(60);
        undervoltage_lockout_in = 1'b0;
        step(70);
        chkEn(1'b0);
        press(40);
        step(5);
        chkEn(1'b0);
        undervoltage_lockout_in = 1'b1;
        step(5);
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        tSupervisor();
        tGlitchOn();
        tShortPress();
        tForced();
        tAbort();
        tUvlo();
        completeRun();
    end
endmodule // tb
`default_nettype wire

/* verilog/pbs_pkg.sv */
// Package of constants shared by the push button power sequencer files.
package pbs_pkg;
    // Tick and interval settings.
    localparam int CLK_FREQ_HZ = 125000000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_FREQ_HZ / 1000 * TICK_MS;
    localparam int TURN_ON_DEBOUNCE_MS = 32;
    localparam int TURN_OFF_DEBOUNCE_MS = 32;
    localparam int INT_MIN_PULSE_MS = 32;
    localparam int TURN_ON_BLANKING_MS = 512;
    localparam int BASE_POWER_DOWN_MS = 64;
    localparam int RESET_STRETCH_MS = 200;
    localparam int PDT_CYCLES_FOR_INT = 16;
    // Extra power-down time per microfarad, in milliseconds.
    localparam int PDT_MS_PER_UF = 6400;
    localparam int MS_WIDTH = 16;
    // Power sequencer states.
    typedef enum logic [1:0] {
        PBS_OFF,
        PBS_BLANK,
        PBS_ON
    } pbs_state_t;
    // Owner of a power-down sequence.
    typedef enum logic [1:0] {
        PBS_OWN_NONE,
        PBS_OWN_BUTTON,
        PBS_OWN_UNDERVOLTAGE_LOCKOUT_IN
    } pbs_owner_t;
endpackage

/* verilog/pbs_supervisor.sv */
// Supply supervisor with a stretched reset output.
`timescale 1ns/100ps
`default_nettype none
module pbs_supervisor #(
    parameter int STRETCH_MS = pbs_pkg::RESET_STRETCH_MS
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic sys_rst,
    // Millisecond tick and synchronised comparator level.
    input wire logic msTick,
    input wire logic voltageOk,
    // Reset output toward the processor.
    output logic supervisorReset_n
);
    logic [pbs_pkg::MS_WIDTH-1:0] stretch_reg;

    // Counts good milliseconds; any dip restarts the stretch.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stretch_reg <= '0;
            supervisorReset_n <= 1'b0;
        end else if (!voltageOk) begin
            stretch_reg <= '0; // R18
            supervisorReset_n <= 1'b0; // R18
        end else if (msTick && !supervisorReset_n) begin
            if (stretch_reg >= pbs_pkg::MS_WIDTH'(STRETCH_MS - 1)) begin
                supervisorReset_n <= 1'b1; // R18
            end else begin
                stretch_reg <= stretch_reg + 1'b1;
            end
        end
    end
endmodule // pbs_supervisor
`default_nettype wire

/* verilog/push_button_power_sequencer.sv */
// Push button on/off sequencer with processor handshake and monitors.
// Behaviour
// R01 - Supply enable asserts only after button low 32 ms while off.
// R02 - Button release during turn-on debounce restarts qualification.
// R03 - Enable assertion starts 512 ms blanking; shutdown request ignored.
// R04 - Button and undervoltage inputs also ignored during blanking.
// R05 - Host drives shutdown request high before blanking ends.
// R06 - Shutdown request still low after blanking releases the enable.
// R07 - After blanking, a low shutdown request releases enable promptly.
// R08 - Short press of 32 ms while on asserts interrupt, power stays.
// R09 - Undervoltage low over 32 ms while on asserts interrupt.
// R10 - Interrupt lasts at least 32 ms, extended while button low.
// R11 - Host finishes housekeeping then pulls shutdown request low.
// R12 - Input held past power-down delay releases interrupt and enable.
// R13 - Power-down delay 64 ms plus programmable capacitor time.
// R14 - While off with undervoltage low, button ignored, enable stays off.
// R15 - Only the button can turn power on.
// R16 - First input starting power-down owns it; other ignored.
// R17 - Enable output polarity is selectable.
// R18 - Reset low while voltage under threshold, then 200 ms more.
// R19 - Supervisor runs independently of all other logic.
// R20 - Power-fail output follows the comparator, independent of all else.
// R21 - Inputs synchronised; intervals derived from a millisecond tick.
// R22 - Reset gives off state, enable released, interrupt high, reset low.
`timescale 1ns/100ps
`default_nettype none
module push_button_power_sequencer #(
    parameter int TICK_CYCLES = pbs_pkg::TICK_CYCLES,
    parameter bit ENABLE_ACTIVE_HIGH = 1'b1,
    parameter int EXTRA_PD_MS_DEFAULT = 0
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic sys_rst,
    // Button, handshake and comparator inputs.
    input wire logic push_button_n,
    input wire logic shutdownRequest_n,
    input wire logic undervoltage_lockout_in,
    input wire logic power_fail_in,
    input wire logic supervised_voltage_in,
    // Extra power-down time in milliseconds, standing for the capacitor.
    input wire logic [pbs_pkg::MS_WIDTH-1:0] power_down_timer_cap,
    // Outputs.
    output logic supplyEnable,
    output logic interrupt_n,
    output logic power_fail_out_n,
    output logic supervisorReset_n
);
    localparam int MW = pbs_pkg::MS_WIDTH;
    localparam int TW = $clog2(TICK_CYCLES + 1);

    function automatic logic reached(input logic [MW-1:0] cnt,
                                     input int limit);
        reached = cnt >= MW'(limit);
    endfunction

    // Two-stage synchronisers for every external level.
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_reg <= 5'h1F;
            sync2_reg <= 5'h1F;
        end else begin
            sync1_reg <= {push_button_n, shutdownRequest_n,
                undervoltage_lockout_in, power_fail_in,
                supervised_voltage_in}; // R21
            sync2_reg <= sync1_reg;
        end
    end
    logic buttonLow;
    logic killLow;
    logic uvLow;
    assign buttonLow = !sync2_reg[4];
    assign killLow = !sync2_reg[3];
    assign uvLow = !sync2_reg[2];

    // Millisecond tick divider.
    logic [TW-1:0] div_reg;
    logic msTick;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_reg <= '0;
            msTick <= 1'b0;
        end else if (div_reg >= TW'(TICK_CYCLES - 1)) begin
            div_reg <= '0;
            msTick <= 1'b1; // R21
        end else begin
            div_reg <= div_reg + 1'b1;
            msTick <= 1'b0;
        end
    end

    pbs_pkg::pbs_state_t state_reg;
    pbs_pkg::pbs_owner_t owner_reg;
    logic [MW-1:0] stateMs_reg;
    logic [MW-1:0] lowMs_reg;
    logic [MW-1:0] intMs_reg;
    logic intActive_reg;
    logic [MW-1:0] pdLimit;
    logic ownerLow;

    // Full power-down delay: base plus the capacitor-derived time.
    assign pdLimit = MW'(pbs_pkg::BASE_POWER_DOWN_MS)
        + power_down_timer_cap
        + MW'(EXTRA_PD_MS_DEFAULT); // R13
    assign ownerLow = (owner_reg == pbs_pkg::PBS_OWN_BUTTON) ? buttonLow
        : (owner_reg == pbs_pkg::PBS_OWN_UNDERVOLTAGE_LOCKOUT_IN) ? uvLow : 1'b0;

    logic forceOff;
    assign forceOff = ownerLow && msTick
        && (lowMs_reg + 1'b1 >= pdLimit); // R12

    // Main power state.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= pbs_pkg::PBS_OFF; // R22
            stateMs_reg <= '0;
        end else begin
            unique case (state_reg)
                pbs_pkg::PBS_OFF: begin
                    if (!buttonLow || uvLow) begin
                        stateMs_reg <= '0; // R02 R14
                    end else if (msTick) begin
                        if (reached(stateMs_reg + 1'b1,
                                pbs_pkg::TURN_ON_DEBOUNCE_MS)) begin
                            state_reg <= pbs_pkg::PBS_BLANK; // R01 R15
                            stateMs_reg <= '0;
                        end else begin
                            stateMs_reg <= stateMs_reg + 1'b1;
                        end
                    end
                end
                pbs_pkg::PBS_BLANK: begin
                    if (msTick) begin
                        stateMs_reg <= stateMs_reg + 1'b1;
                        if (reached(stateMs_reg + 1'b1,
                                pbs_pkg::TURN_ON_BLANKING_MS)) begin
                            // R03 R04
                            state_reg <= killLow ? pbs_pkg::PBS_OFF
                                : pbs_pkg::PBS_ON; // R06
                            stateMs_reg <= '0;
                        end
                    end
                end
                pbs_pkg::PBS_ON: begin
                    if (killLow || forceOff) begin
                        state_reg <= pbs_pkg::PBS_OFF; // R07 R12
                        stateMs_reg <= '0;
                    end
                end
            endcase
        end
    end

    // Power-down owner and its held-low time.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            owner_reg <= pbs_pkg::PBS_OWN_NONE;
            lowMs_reg <= '0;
        end else if (state_reg != pbs_pkg::PBS_ON || killLow || forceOff) begin
            owner_reg <= pbs_pkg::PBS_OWN_NONE;
            lowMs_reg <= '0;
        end else if (owner_reg == pbs_pkg::PBS_OWN_NONE) begin
            lowMs_reg <= '0;
            if (buttonLow) begin
                owner_reg <= pbs_pkg::PBS_OWN_BUTTON; // R16
            end else if (uvLow) begin
                owner_reg <= pbs_pkg::PBS_OWN_UNDERVOLTAGE_LOCKOUT_IN; // R16
            end
        end else if (!ownerLow) begin
            owner_reg <= pbs_pkg::PBS_OWN_NONE; // R16
            lowMs_reg <= '0;
        end else if (msTick) begin
            lowMs_reg <= lowMs_reg + 1'b1;
        end
    end

    // Interrupt pulse: raised after the off debounce, held a minimum time.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            intActive_reg <= 1'b0;
            intMs_reg <= '0;
        end else if (state_reg != pbs_pkg::PBS_ON || killLow || forceOff) begin
            intActive_reg <= 1'b0; // R12
            intMs_reg <= '0;
        end else if (!intActive_reg) begin
            intMs_reg <= '0;
            if (ownerLow && msTick && reached(lowMs_reg + 1'b1,
                    pbs_pkg::TURN_OFF_DEBOUNCE_MS)) begin
                intActive_reg <= 1'b1; // R08 R09
            end
        end else if (msTick) begin
            if (!reached(intMs_reg, pbs_pkg::INT_MIN_PULSE_MS)) begin
                intMs_reg <= intMs_reg + 1'b1;
            end else if (!buttonLow) begin
                intActive_reg <= 1'b0; // R10
            end
        end
    end

    // Registered outputs.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            supplyEnable <= !ENABLE_ACTIVE_HIGH; // R22
            interrupt_n <= 1'b1;
            power_fail_out_n <= 1'b1;
        end else begin
            supplyEnable <= (state_reg != pbs_pkg::PBS_OFF)
                ~^ ENABLE_ACTIVE_HIGH; // R17
            interrupt_n <= !intActive_reg;
            power_fail_out_n <= sync2_reg[1]; // R20
        end
    end

    pbs_supervisor #(
        .STRETCH_MS(pbs_pkg::RESET_STRETCH_MS)
    ) supervisor (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .msTick(msTick),
        .voltageOk(sync2_reg[0]),
        .supervisorReset_n(supervisorReset_n) // R19
    );
endmodule // push_button_power_sequencer
`default_nettype wire
